// ===== shared/fcs_pkg.sv
// Constants, command codes and types of the flash command sequencer host
package fcs_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;

  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STROBE_NS = 70;
  localparam int RECOVER_NS = 100;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Waits after a command sequence, least times, rounded up
  localparam int PROG_WAIT_US = 50;
  localparam int ID_WAIT_US = 10;
  localparam int ERASE_WAIT_MS = 200;
  localparam int PROG_WAIT_CYC = (PROG_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ID_WAIT_CYC = (ID_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_WAIT_CYC = (ERASE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command addresses and data bytes; only the low byte carries the command
  localparam logic [ADDR_W-1:0] CMD_ADDR_A = 17'h05555;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B = 17'h02AAA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_LOCKOUT_SET = 16'h0040;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ID_ENTRY = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_ID_EXIT = 16'h00F0;

  // Sector select addresses: parameter blocks and main (plus boot when unlocked)
  localparam logic [ADDR_W-1:0] SECTOR_PARAM1 = 17'h03000;
  localparam logic [ADDR_W-1:0] SECTOR_PARAM2 = 17'h05000;
  localparam logic [ADDR_W-1:0] SECTOR_MAIN = 17'h1F000;
  localparam logic [ADDR_W-1:0] ID_LOCKOUT_ADDR = 17'h00002;

  // Number of writes per sequence, minus one
  localparam logic [2:0] LAST_SIX = 3'h5;
  localparam logic [2:0] LAST_FOUR = 3'h3;
  localparam logic [2:0] LAST_THREE = 3'h2;
  localparam logic [2:0] LAST_ONE = 3'h0;

  typedef enum logic [3:0] {
    FCS_OP_READ,
    FCS_OP_HW_ID,
    FCS_OP_PROGRAM,
    FCS_OP_CHIP_ERASE,
    FCS_OP_SECTOR_ERASE,
    FCS_OP_LOCKOUT_SET,
    FCS_OP_ID_ENTRY,
    FCS_OP_ID_EXIT3,
    FCS_OP_ID_EXIT1
  } fcs_op_t;

endpackage

// ===== verilog/fcs_bus_cycle.sv
// One asynchronous flash bus cycle, read or write, with registered pins
`timescale 1ns/1ps
module fcs_bus_cycle (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [fcs_pkg::ADDR_W-1:0] addr_in,
  input wire logic [fcs_pkg::DATA_W-1:0] wdata,
  output logic done,
  output logic [fcs_pkg::DATA_W-1:0] rdata,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [fcs_pkg::ADDR_W-1:0] addr,
  output logic [fcs_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [fcs_pkg::DATA_W-1:0] dq_in
);
  import fcs_pkg::*;

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOVER} fcs_bc_state_t;

  fcs_bc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic done_reg, done_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic ce_n_reg, ce_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    unique case (state_reg)
      BC_IDLE: begin
        if (start) begin
          wr_next = wr;
          addr_next = addr_in;
          dq_next = wdata;
          dq_oe_next = wr;
          ce_n_next = 1'b0;
          state_next = BC_SETUP;
        end
      end
      BC_SETUP: begin
        // Reads drive the strobe only with write enable high
        we_n_next = !wr_reg;
        oe_n_next = wr_reg;
        cnt_next = STROBE_CYC;
        state_next = BC_STROBE;
      end
      BC_STROBE: begin
        if (cnt_reg == 4'h1) begin
          if (!wr_reg) begin
            rdata_next = dq_in;
          end
          we_n_next = 1'b1;
          oe_n_next = 1'b1;
          cnt_next = RECOVER_CYC;
          state_next = BC_RECOVER;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      BC_RECOVER: begin
        // Data and address held through the rising strobe edge, then data released; address kept
        ce_n_next = 1'b1;
        dq_oe_next = 1'b0;
        if (cnt_reg == 4'h1) begin
          done_next = 1'b1;
          state_next = BC_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= BC_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      addr_reg <= 17'h00000;
      dq_reg <= 16'h0000;
      dq_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  assign done = done_reg;
  assign rdata = rdata_reg;
  assign ce_n = ce_n_reg;
  assign oe_n = oe_n_reg;
  assign we_n = we_n_reg;
  assign addr = addr_reg;
  assign dq_out = dq_reg;
  assign dq_oe = dq_oe_reg;

endmodule

// ===== verilog/fcs_host.sv
// Host-side command sequencer that drives an asynchronous 128K x 16 flash
// How it works
// - Chip erase is six writes ending 10 to 5555, then 200 ms wait.
// - Sector erase is the erase prefix plus 30 to an address in the sector.
// - Word program is AA, 55, A0 then data word at target address.
// - After the fourth program write the host waits 50 us.
// - No read cycle is issued between first and fourth program write.
// - Lockout set is the erase prefix plus 40 to 5555, then 200 ms.
// - After a sector erase the host pauses 200 ms.
// - Id entry is AA, 55, 90, then 10 us before reading.
`timescale 1ns/1ps
module fcs_host #(
  parameter int ERASE_WAIT = fcs_pkg::ERASE_WAIT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fcs_pkg::fcs_op_t cmd_op,
  input wire logic [fcs_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [fcs_pkg::DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic [fcs_pkg::DATA_W-1:0] rsp_data,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic id_voltage_enable,
  output logic [fcs_pkg::ADDR_W-1:0] flash_addr,
  output logic [fcs_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [fcs_pkg::DATA_W-1:0] flash_dq_in
);
  import fcs_pkg::*;

  typedef enum logic [2:0] {SQ_IDLE, SQ_ISSUE, SQ_BUSY, SQ_WAIT} fcs_sq_state_t;

  fcs_sq_state_t state_reg, state_next;
  fcs_op_t op_reg, op_next;
  logic [ADDR_W-1:0] uaddr_reg, uaddr_next;
  logic [DATA_W-1:0] udata_reg, udata_next;
  logic [2:0] idx_reg, idx_next;
  logic [31:0] wait_reg, wait_next;
  logic ready_reg, ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [DATA_W-1:0] rsp_data_reg, rsp_data_next;
  logic hv_reg, hv_next;
  logic rst_pin_reg, rst_pin_next;
  logic bc_start_reg, bc_start_next;
  logic bc_wr_reg, bc_wr_next;
  logic [ADDR_W-1:0] bc_addr_reg, bc_addr_next;
  logic [DATA_W-1:0] bc_data_reg, bc_data_next;
  logic bc_done;
  logic [DATA_W-1:0] bc_rdata;

  function automatic logic is_read(input fcs_op_t op);
    return (op == FCS_OP_READ) || (op == FCS_OP_HW_ID);
  endfunction

  function automatic logic [2:0] last_step(input fcs_op_t op);
    unique case (op)
      FCS_OP_PROGRAM: return LAST_FOUR;
      FCS_OP_CHIP_ERASE, FCS_OP_SECTOR_ERASE, FCS_OP_LOCKOUT_SET: return LAST_SIX;
      FCS_OP_ID_ENTRY, FCS_OP_ID_EXIT3: return LAST_THREE;
      default: return LAST_ONE;
    endcase
  endfunction

  // Address of write number idx; the unlock prefix is shared by all sequences except FCS_OP_ID_EXIT1
  function automatic logic [ADDR_W-1:0] step_addr(input fcs_op_t op, input logic [2:0] idx,
                                                  input logic [ADDR_W-1:0] ua);
    if (op == FCS_OP_ID_EXIT1) begin
      return ua;
    end
    if (idx == last_step(op)) begin
      if (op == FCS_OP_PROGRAM || op == FCS_OP_SECTOR_ERASE) begin
        return ua;
      end
      return CMD_ADDR_A;
    end
    if (idx == 3'h1 || idx == 3'h4) begin
      return CMD_ADDR_B;
    end
    return CMD_ADDR_A;
  endfunction

  function automatic logic [DATA_W-1:0] step_data(input fcs_op_t op, input logic [2:0] idx,
                                                  input logic [DATA_W-1:0] ud);
    if (idx == last_step(op)) begin
      unique case (op)
        FCS_OP_PROGRAM: return ud;
        FCS_OP_CHIP_ERASE: return CMD_CHIP_ERASE;
        FCS_OP_SECTOR_ERASE: return CMD_SECTOR_ERASE;
        FCS_OP_LOCKOUT_SET: return CMD_LOCKOUT_SET;
        FCS_OP_ID_ENTRY: return CMD_ID_ENTRY;
        default: return CMD_ID_EXIT;
      endcase
    end
    // Upper byte always zero on command writes
    unique case (idx)
      3'h0, 3'h3: return CMD_UNLOCK1;
      3'h1, 3'h4: return CMD_UNLOCK2;
      default: return (op == FCS_OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
    endcase
  endfunction

  function automatic logic [31:0] wait_of(input fcs_op_t op);
    unique case (op)
      FCS_OP_PROGRAM: return 32'(PROG_WAIT_CYC);
      FCS_OP_CHIP_ERASE, FCS_OP_SECTOR_ERASE, FCS_OP_LOCKOUT_SET:
        return 32'(ERASE_WAIT);
      default: return 32'(ID_WAIT_CYC);
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    uaddr_next = uaddr_reg;
    udata_next = udata_reg;
    idx_next = idx_reg;
    wait_next = wait_reg;
    ready_next = ready_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    hv_next = hv_reg;
    rst_pin_next = 1'b1;
    bc_start_next = 1'b0;
    bc_wr_next = bc_wr_reg;
    bc_addr_next = bc_addr_reg;
    bc_data_next = bc_data_reg;
    unique case (state_reg)
      SQ_IDLE: begin
        // Ready rises on the same edge that releases the flash reset pin
        if (!rst_pin_reg) begin
          ready_next = 1'b1;
        end
        if (cmd_valid && ready_reg) begin
          op_next = cmd_op;
          uaddr_next = cmd_addr;
          udata_next = cmd_data;
          idx_next = 3'h0;
          ready_next = 1'b0;
          hv_next = (cmd_op == FCS_OP_HW_ID);
          state_next = SQ_ISSUE;
        end
      end
      SQ_ISSUE: begin
        bc_start_next = 1'b1;
        if (is_read(op_reg)) begin
          bc_wr_next = 1'b0;
          // Hardware id keeps every address bit low except bit zero
          bc_addr_next = (op_reg == FCS_OP_HW_ID) ? {{(ADDR_W-1){1'b0}}, uaddr_reg[0]} : uaddr_reg;
          bc_data_next = 16'h0000;
        end else begin
          bc_wr_next = 1'b1;
          bc_addr_next = step_addr(op_reg, idx_reg, uaddr_reg);
          bc_data_next = step_data(op_reg, idx_reg, udata_reg);
        end
        state_next = SQ_BUSY;
      end
      SQ_BUSY: begin
        if (bc_done) begin
          if (is_read(op_reg)) begin
            rsp_data_next = bc_rdata;
            rsp_valid_next = 1'b1;
            hv_next = 1'b0;
            ready_next = 1'b1;
            state_next = SQ_IDLE;
          end else if (idx_reg == last_step(op_reg)) begin
            wait_next = wait_of(op_reg);
            state_next = SQ_WAIT;
          end else begin
            // Writes follow back to back; no read slips
            idx_next = idx_reg + 3'h1;
            state_next = SQ_ISSUE;
          end
        end
      end
      SQ_WAIT: begin
        // Bus stays idle until the device has finished
        if (wait_reg <= 32'h00000001) begin
          rsp_valid_next = 1'b1;
          ready_next = 1'b1;
          state_next = SQ_IDLE;
        end else begin
          wait_next = wait_reg - 32'h00000001;
        end
      end
      default: state_next = SQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SQ_IDLE;
      op_reg <= FCS_OP_READ;
      uaddr_reg <= 17'h00000;
      udata_reg <= 16'h0000;
      idx_reg <= 3'h0;
      wait_reg <= 32'h00000000;
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
      hv_reg <= 1'b0;
      rst_pin_reg <= 1'b0;
      bc_start_reg <= 1'b0;
      bc_wr_reg <= 1'b0;
      bc_addr_reg <= 17'h00000;
      bc_data_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      uaddr_reg <= uaddr_next;
      udata_reg <= udata_next;
      idx_reg <= idx_next;
      wait_reg <= wait_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      hv_reg <= hv_next;
      rst_pin_reg <= rst_pin_next;
      bc_start_reg <= bc_start_next;
      bc_wr_reg <= bc_wr_next;
      bc_addr_reg <= bc_addr_next;
      bc_data_reg <= bc_data_next;
    end
  end

  fcs_bus_cycle u_cycle (
    .clk(clk),
    .resetn(resetn),
    .start(bc_start_reg),
    .wr(bc_wr_reg),
    .addr_in(bc_addr_reg),
    .wdata(bc_data_reg),
    .done(bc_done),
    .rdata(bc_rdata),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n),
    .addr(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe),
    .dq_in(flash_dq_in)
  );

  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign id_voltage_enable = hv_reg;
  assign flash_reset_n = rst_pin_reg;

endmodule

// ===== verification/fcs_host_monitor.sv
// Pin and handshake checks for the flash host
`timescale 1ns/1ps
module fcs_host_monitor #(
  parameter int ERASE_WAIT = fcs_pkg::ERASE_WAIT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire fcs_pkg::fcs_op_t cmd_op,
  input wire logic rsp_valid,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [fcs_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fcs_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe
);
  import fcs_pkg::*;
  fcs_op_t op_q;
  logic we_q;
  int gap;
  // Cycles since the last write strobe ended
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= FCS_OP_READ;
      we_q <= 1'b1;
      gap <= 0;
    end else begin
      we_q <= flash_we_n;
      if (cmd_valid && cmd_ready)
        op_q <= cmd_op;
      if (flash_we_n && !we_q)
        gap <= 0;
      else if (gap < 8000000)
        gap <= gap + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_read_pins;
    !flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n;
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("read strobe with bad pins");
  property p_write_pins;
    !flash_we_n |-> flash_dq_oe && flash_oe_n && !flash_ce_n;
  endproperty
  a_write_pins: assert property (p_write_pins)
    else $error("write strobe with bad pins");
  property p_we_strobe;
    $fell(flash_we_n) |-> $stable(flash_addr) ##1 !flash_we_n && $stable(flash_dq_out)
      ##1 flash_we_n && $stable(flash_addr);
  endproperty
  a_we_strobe: assert property (p_we_strobe)
    else $error("write strobe shape or hold wrong");
  property p_cmd_byte;
    !flash_we_n && op_q != FCS_OP_PROGRAM |-> flash_dq_out[15:8] == 8'h00;
  endproperty
  a_cmd_byte: assert property (p_cmd_byte)
    else $error("command write with upper byte set");
  property p_no_read_in_prog;
    op_q == FCS_OP_PROGRAM && !cmd_ready |-> flash_oe_n;
  endproperty
  a_no_read_in_prog: assert property (p_no_read_in_prog)
    else $error("read inside program sequence");
  property p_prog_wait;
    rsp_valid && op_q == FCS_OP_PROGRAM |-> gap >= PROG_WAIT_CYC;
  endproperty
  a_prog_wait: assert property (p_prog_wait)
    else $error("program wait too short");
  property p_erase_wait;
    rsp_valid && op_q inside {FCS_OP_CHIP_ERASE, FCS_OP_SECTOR_ERASE, FCS_OP_LOCKOUT_SET}
      |-> gap >= ERASE_WAIT;
  endproperty
  a_erase_wait: assert property (p_erase_wait)
    else $error("erase wait too short");
  property p_id_wait;
    rsp_valid && op_q == FCS_OP_ID_ENTRY |-> gap >= ID_WAIT_CYC;
  endproperty
  a_id_wait: assert property (p_id_wait)
    else $error("id entry wait too short");
endmodule
bind fcs_host fcs_host_monitor #(.ERASE_WAIT(ERASE_WAIT)) mon_u (
  .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .rsp_valid(rsp_valid), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe)
);

// ===== verification/fcs_flash_model.sv
// Behavioural pin-level model of the flash device
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h0001, // Arbitrary id value
  parameter logic [15:0] DEV_CODE = 16'h0002, // Arbitrary id value
  parameter int PROG_BUSY_NS = 50000 // Longest internal program time
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic hv_en,
  input wire logic [16:0] addr,
  input wire logic [15:0] dq_host,
  output logic dev_oe,
  output logic [15:0] dev_dq
);
  logic [15:0] mem [131072];
  logic [33:0] wr_log [$];
  logic [16:0] sa_q;
  logic [15:0] val, last_q;
  logic [14:0] a;
  logic [7:0] d;
  logic id_mode, locked;
  int step;
  logic [16:0] last_a;
  logic tgl;
  realtime busy_end;
  initial begin
    foreach (mem[k]) mem[k] = 16'hFFFF;
    step = 0;
    id_mode = 1'b0;
    locked = 1'b0;
    last_q = 16'h0000;
    val = 16'h0000;
    tgl = 1'b0;
    busy_end = 0.0;
  end
  assign dev_oe = !ce_n && !oe_n && we_n && reset_n;
  // Released bus shows the inverse of the last value
  assign dev_dq = dev_oe ? val : ~last_q;
  always @(negedge oe_n) begin
    // Status bits while the last program is still running
    if ($realtime < busy_end && addr == last_a) begin
      tgl = !tgl;
      val = {mem[addr][15:8], ~mem[addr][7], tgl, mem[addr][5:0]};
    end else if (id_mode && addr[16:2] == 15'h0)
      val = addr[1] ? {15'h0, locked} : (addr[0] ? DEV_CODE : MFR_CODE);
    else if (hv_en && addr[16:1] == 16'h0)
      val = addr[0] ? DEV_CODE : MFR_CODE;
    else
      val = mem[addr];
    step = 0;
  end
  always @(posedge oe_n) last_q = val;
  always @(negedge reset_n) begin
    step = 0;
    id_mode = 1'b0;
  end
  always @(negedge we_n) sa_q = addr;
  always @(posedge we_n) if (!ce_n) begin
    wr_log.push_back({1'b1, addr, dq_host});
    a = addr[14:0];
    d = dq_host[7:0];
    if (step == 0 && d == 8'hF0) begin
      id_mode = 1'b0;
    end else if (step == 6) begin
      step = 0;
      if (!(locked && addr < 17'h02000)) mem[addr] = mem[addr] & dq_host;
      last_a = addr;
      busy_end = $realtime + PROG_BUSY_NS;
    end else if (step == 5) begin
      step = 0;
      if (a == 15'h5555 && d == 8'h10) begin
        for (int k = 0; k < 131072; k++)
          if (!locked || k >= 'h2000) mem[k] = 16'hFFFF;
      end else if (d == 8'h30) begin
        for (int k = 0; k < 131072; k++)
          if (sa_q[16:12] == 5'h1F ? (k >= 'h6000 || (k < 'h2000 && !locked))
              : (k[16:13] == sa_q[16:13])) mem[k] = 16'hFFFF;
      end else if (a == 15'h5555 && d == 8'h40) begin
        locked = 1'b1;
      end
    end else if (step == 2 && a == 15'h5555) begin
      step = (d == 8'h80) ? 3 : ((d == 8'hA0) ? 6 : 0);
      if (d == 8'h90) id_mode = 1'b1;
      if (d == 8'hF0) id_mode = 1'b0;
    end else begin
      step = (((step == 0 || step == 3) && a == 15'h5555 && d == 8'hAA) ||
        ((step == 1 || step == 4) && a == 15'h2AAA && d == 8'h55)) ? step + 1 : 0;
    end
  end
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the flash host against the device model
`timescale 1ns/1ps
module testbench;
  import fcs_pkg::*;
  localparam logic [15:0] MFR = 16'h0A5C; // Arbitrary id value
  localparam logic [15:0] DEV = 16'h0B3E; // Arbitrary id value
  logic clk, resetn, cmd_valid, cmd_ready, rsp_valid, ce_n, oe_n, we_n, frst_n, hv, dq_oe, dev_oe;
  fcs_op_t cmd_op;
  logic [16:0] cmd_addr, addr;
  logic [15:0] cmd_data, rsp_data, dq_out, dq_in, dev_dq;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  assign dq_in = dq_oe ? dq_out : dev_dq;
  fcs_host #(.ERASE_WAIT(50)) dut_u (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_reset_n(frst_n), .id_voltage_enable(hv), .flash_addr(addr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  fcs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) m_u (.ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .reset_n(frst_n), .hv_en(hv), .addr(addr), .dq_host(dq_out),
    .dev_oe(dev_oe), .dev_dq(dev_dq));
  task automatic tally_and_finish;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input fcs_op_t op, input logic [16:0] a, input logic [15:0] d);
    int n;
    n = 0;
    m_u.wr_log.delete();
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    cmp("response seen", 34'h1, 34'(n < 20000));
  endtask
  task automatic rd(input logic [16:0] a, input logic [15:0] exp);
    run(FCS_OP_READ, a, 16'h0000);
    cmp("read data", 34'(exp), 34'(rsp_data));
  endtask
  task automatic chk(input int n, input logic [7:0] d3, input logic [16:0] la,
                     input logic [15:0] ld);
    logic [16:0] pa [5];
    logic [7:0] pd [5];
    pa = '{CMD_ADDR_A, CMD_ADDR_B, CMD_ADDR_A, CMD_ADDR_A, CMD_ADDR_B};
    pd = '{8'hAA, 8'h55, d3, 8'hAA, 8'h55};
    cmp("write count", 34'(n), 34'(m_u.wr_log.size()));
    for (int i = 0; i < n && i < m_u.wr_log.size(); i++)
      cmp("bus write", (i == n - 1) ? {1'b1, la, ld} : {1'b1, pa[i], 8'h00, pd[i]}, m_u.wr_log[i]);
  endtask
  task automatic t_program;
    run(FCS_OP_PROGRAM, 17'h01234, 16'h5AC3);
    chk(4, 8'hA0, 17'h01234, 16'h5AC3);
    rd(17'h01234, 16'h5AC3);
    run(FCS_OP_PROGRAM, 17'h01234, 16'hF00F);
    rd(17'h01234, 16'h5003);
  endtask
  task automatic t_hwid;
    run(FCS_OP_HW_ID, 17'h1FFFE, 16'h0000);
    cmp("id read", 34'(MFR), 34'(rsp_data));
    run(FCS_OP_HW_ID, 17'h1FFFF, 16'h0000);
    cmp("id read", 34'(DEV), 34'(rsp_data));
  endtask
  task automatic t_idmode;
    run(FCS_OP_ID_ENTRY, 17'h0, 16'h0000);
    chk(3, 8'h00, CMD_ADDR_A, CMD_ID_ENTRY);
    rd(17'h00000, MFR);
    rd(17'h00001, DEV);
    rd(ID_LOCKOUT_ADDR, 16'h0000);
    run(FCS_OP_ID_EXIT1, 17'h1ABCD, 16'h0000);
    chk(1, 8'h00, 17'h1ABCD, CMD_ID_EXIT);
    rd(17'h00001, 16'hFFFF);
    run(FCS_OP_ID_ENTRY, 17'h0, 16'h0000);
    run(FCS_OP_ID_EXIT3, 17'h0, 16'h0000);
    chk(3, 8'h00, CMD_ADDR_A, CMD_ID_EXIT);
    rd(17'h01234, 16'h5003);
  endtask
  task automatic t_erase;
    run(FCS_OP_PROGRAM, 17'h02100, 16'h1234);
    run(FCS_OP_SECTOR_ERASE, 17'h03456, 16'h0000);
    chk(6, 8'h80, 17'h03456, CMD_SECTOR_ERASE);
    rd(17'h02100, 16'hFFFF);
    run(FCS_OP_CHIP_ERASE, 17'h0, 16'h0000);
    chk(6, 8'h80, CMD_ADDR_A, CMD_CHIP_ERASE);
    rd(17'h01234, 16'hFFFF);
    run(FCS_OP_LOCKOUT_SET, 17'h0, 16'h0000);
    chk(6, 8'h80, CMD_ADDR_A, CMD_LOCKOUT_SET);
    run(FCS_OP_ID_ENTRY, 17'h0, 16'h0000);
    rd(ID_LOCKOUT_ADDR, 16'h0001);
    run(FCS_OP_ID_EXIT1, 17'h0, 16'h0000);
  endtask
  task automatic t_reset;
    run(FCS_OP_ID_ENTRY, 17'h0, 16'h0000);
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    cmp("reset pin", 34'h0, 34'(frst_n));
    resetn = 1'b1;
    rd(17'h00001, 16'hFFFF);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (dev_oe) begin
      cmp("bus contention", 34'h0, 34'(dq_oe));
    end
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = FCS_OP_READ;
    cmd_addr = 17'h0;
    cmd_data = 16'h0000;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    cmp("idle pins", 34'h39, 34'({ce_n, oe_n, we_n, dq_oe, hv, frst_n}));
    t_program();
    t_hwid();
    t_idmode();
    t_erase();
    t_reset();
    tally_and_finish();
  end
endmodule
